//--- design/sbc_calc.sv
// Current and power arithmetic unit, two registered stages.
// Assumes start is a one-cycle pulse with operands stable that cycle.
`default_nettype none
module sbc_calc
  import sbc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Operands and results
  sbc_calc_if.calc  cif
);
  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_quot;
  logic        [28:0] pwr_prod;
  logic        [15:0] cur_mag;
  logic               stage1_q;

  assign cur_prod = cif.shunt * $signed({1'b0, cif.cal});
  assign cur_quot = cur_prod / CUR_DIVISOR;
  assign cur_mag  = cif.current[15] ? 16'(-cif.current) : 16'(cif.current);
  assign pwr_prod = cur_mag * cif.bus;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cif.current <= 16'sh0000;
      stage1_q    <= 1'b0;
    end
    else
    begin
      stage1_q <= cif.start;
      if (cif.start)
        cif.current <= cur_quot[15:0];
    end
  end

  // Power uses the magnitude of the current: the result is unsigned
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cif.power <= 16'h0000;
      cif.done  <= 1'b0;
    end
    else
    begin
      cif.done <= stage1_q;
      if (stage1_q)
        cif.power <= 16'(pwr_prod / PWR_DIVISOR);
    end
  end
endmodule
`default_nettype wire

//--- design/sbc_calc_if.sv
// Interface between the sequencer and its current/power arithmetic unit.
// Assumes both ends run on the same clock.
`default_nettype none
interface sbc_calc_if;
  logic               start;
  logic signed [15:0] shunt;
  logic        [12:0] bus;
  logic        [15:0] cal;
  logic signed [15:0] current;
  logic        [15:0] power;
  logic               done;

  modport seq  (output start, output shunt, output bus, output cal,
                input current, input power, input done);
  modport calc (input start, input shunt, input bus, input cal,
                output current, output power, output done);
endinterface
`default_nettype wire

//--- design/sbc_pkg.sv
// Package for the shunt/bus conversion sequencer: register map, config
// fields, reset values, mode codes and timing counts.
// Assumes a single 40 MHz clock domain.
`default_nettype none
package sbc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CONFIG  = 4'h0;
  localparam logic [3:0] IDX_SHUNT   = 4'h1;
  localparam logic [3:0] IDX_BUS     = 4'h2;
  localparam logic [3:0] IDX_POWER   = 4'h3;
  localparam logic [3:0] IDX_CURRENT = 4'h4;
  localparam logic [3:0] IDX_CAL     = 4'h5;
  localparam logic [3:0] IDX_STATUS  = 4'h6;

  // Configuration field positions
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_SAVG_LSB  = 3;
  localparam int CFG_BAVG_LSB  = 7;
  localparam int CFG_GAIN_LSB  = 11;
  localparam int CFG_BUS_RANGE_SELECT_BIT  = 13;
  localparam int CFG_WIDTH     = 14;
  localparam int BUS_READY_BIT = 1;
  localparam int BUS_DATA_LSB  = 3;

  // 12-bit, gain /8, 32 V range, continuous shunt and bus
  localparam logic [13:0] CFG_RESET = 14'h399f;

  typedef enum logic [2:0] {
    SBC_MODE_PDOWN    = 3'b000,
    SBC_MODE_TRIG_SH  = 3'b001,
    SBC_MODE_TRIG_BUS = 3'b010,
    SBC_MODE_TRIG_ALL = 3'b011,
    SBC_MODE_OFF      = 3'b100,
    SBC_MODE_CONT_SH  = 3'b101,
    SBC_MODE_CONT_BUS = 3'b110,
    SBC_MODE_CONT_ALL = 3'b111
  } sbc_mode_t;

  typedef enum logic [1:0] {
    SBC_ST_IDLE  = 2'b00,
    SBC_ST_SHUNT = 2'b01,
    SBC_ST_BUS   = 2'b10,
    SBC_ST_CALC  = 2'b11
  } sbc_state_t;

  // Full-scale ranges
  localparam logic [8:0] SHUNT_FS_BASE_MV = 9'd40;
  localparam logic [5:0] BUS_FS_LOW_V     = 6'd16;
  localparam logic [5:0] BUS_FS_HIGH_V    = 6'd32;

  // Arithmetic scaling
  localparam int CUR_DIVISOR = 4096;
  localparam int PWR_DIVISOR = 5000;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RECOVERY_NS   = 40000;
  localparam int RECOVERY_CYC  = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

//--- design/sbc_top.sv
// Shunt/bus conversion sequencer with an AHB-Lite register slave.
// Assumes an external converter answering adc_req with an adc_done pulse.
// What this block does
// - Mode 111 repeats shunt then bus conversion without host action.
// - Each cycle takes the shunt sample count, then the bus sample count.
// - Modes convert shunt only or bus only, continuous or triggered.
// - Current and power are computed after conversions; the sequencer waits in SBC_ST_CALC until done.
// - Leaving power-down, wait the 40 us recovery before converting.
// - Converter-off mode halts all conversions until another mode is written.
// - Every write of a triggered mode starts one single-shot conversion.
// - Result registers always readable, holding the last completed values.
// - Ready flag sets only after conversions, averaging and arithmetic finish.
// - Config writes clear the ready flag, except power-down or off modes.
// - Reading the status register clears the ready flag.
// - A convert pin single-shot start clears the ready flag.
// - Shunt gain widens base range by 2, 4 or 8, up to 320 mV.
// - Bus range selects 16 V or 32 V full scale.
// - Divide-by-two gain gives an 80 mV shunt full scale.
// - Shunt and bus resolution and averaging are separate fields.
// - Bus range select is bit 13 of the config register at 00h.
// - Reset gives 12-bit, 320 mV, 32 V range, continuous both.
// - Current equals shunt times calibration divided by 4096.
// - Power equals current magnitude times bus voltage divided by 5000.
`default_nettype none
module sbc_top
  import sbc_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int BUS_W  = 13
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  // Convert pin, synchronous to clk
  input  wire logic              convert_pin,
  // Converter front end
  output logic                   adc_req,
  output logic                   adc_chan_bus,
  output logic      [1:0]        adc_res,
  input  wire logic              adc_done,
  input  wire logic [DATA_W-1:0] adc_data,
  // Range controls
  output logic      [1:0]        shunt_gain,
  output logic      [8:0]        shunt_fs_mv,
  output logic                   bus_range_select,
  output logic      [5:0]        bus_fs_v,
  output logic                   powered_down
);
  sbc_calc_if cif ();

  sbc_calc u_calc (
    .clk (clk),
    .rst (rst),
    .cif (cif)
  );

  logic        [CFG_WIDTH-1:0] cfg_q;
  logic signed [DATA_W-1:0]    shunt_q;
  logic        [BUS_W-1:0]     bus_q;
  logic        [15:0]          cal_q;
  logic                        conversion_ready_flag_q;
  logic                        trig_pend_q;
  logic                        pin_q;
  logic        [10:0]          wake_cnt_q;
  sbc_state_t                  state_q;
  logic        [6:0]           samp_cnt_q;
  logic signed [DATA_W+6:0]    acc_q;
  logic                        calc_start_q;
  logic                        wr_pend_q;
  logic        [3:0]           wr_idx_q;
  logic        [31:0]          hrdata_q;

  // Bus decode
  logic             addr_take;
  logic [3:0]       addr_idx;
  logic             cfg_wr;
  logic             status_rd;
  logic [2:0]       new_mode;
  sbc_mode_t        mode;
  logic             mode_cont;
  logic             new_trig;
  logic             pin_rise;
  logic             pin_trig;
  logic             seq_go;
  logic [3:0]       savg_field;
  logic [3:0]       bavg_field;
  logic [2:0]       avg_log2;
  logic [6:0]       avg_last;
  logic signed [DATA_W+6:0] acc_sum;
  logic [DATA_W-1:0] avg_val;

  function automatic logic [2:0] avg_shift(input logic [3:0] field);
    avg_shift = field[3] ? field[2:0] : 3'd0;
  endfunction

  assign mode       = sbc_mode_t'(cfg_q[CFG_MODE_LSB +: 3]);
  assign mode_cont  = mode[2];
  assign savg_field = cfg_q[CFG_SAVG_LSB +: 4];
  assign bavg_field = cfg_q[CFG_BAVG_LSB +: 4];

  assign addr_take = hsel && htrans[1] && hready;
  assign addr_idx  = haddr[5:2];
  assign cfg_wr    = wr_pend_q && (wr_idx_q == IDX_CONFIG);
  assign new_mode  = hwdata[CFG_MODE_LSB +: 3];
  assign status_rd = addr_take && !hwrite && (addr_idx == IDX_STATUS) && (haddr[31:6] == 26'h0);
  // Triggered codes have bit 2 clear and are neither power-down nor off
  assign new_trig  = cfg_wr && !new_mode[2] && (new_mode != 3'b000);
  assign pin_rise  = convert_pin && !pin_q;
  assign pin_trig  = pin_rise && !mode_cont && (mode != SBC_MODE_PDOWN);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Address phase capture; every transfer completes with zero wait states
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 4'h0;
    end
    else
    begin
      wr_pend_q <= addr_take && hwrite && (haddr[31:6] == 26'h0);
      wr_idx_q  <= addr_idx;
    end
  end

  // Read data is fetched at the address phase so it stands from a flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hrdata_q <= 32'h0000_0000;
    else if (addr_take && !hwrite)
    begin
      hrdata_q <= 32'h0000_0000;
      if (haddr[31:6] != 26'h0)
        hrdata_q <= 32'h0000_0000;
      else if (addr_idx == IDX_CONFIG)
        hrdata_q <= 32'(cfg_q);
      else if (addr_idx == IDX_SHUNT)
        hrdata_q <= 32'({16'h0000, shunt_q});
      else if (addr_idx == IDX_BUS)
        hrdata_q <= 32'({bus_q, 1'b0, conversion_ready_flag_q, 1'b0});
      else if (addr_idx == IDX_POWER)
        hrdata_q <= 32'(cif.power);
      else if (addr_idx == IDX_CURRENT)
        hrdata_q <= 32'({16'h0000, cif.current});
      else if (addr_idx == IDX_CAL)
        hrdata_q <= 32'(cal_q);
      else if (addr_idx == IDX_STATUS)
        hrdata_q <= 32'(conversion_ready_flag_q);
    end
  end

  // Writable registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q <= CFG_RESET;
      cal_q <= 16'h0000;
    end
    else if (wr_pend_q)
    begin
      if (wr_idx_q == IDX_CONFIG)
        cfg_q <= hwdata[CFG_WIDTH-1:0];
      else if (wr_idx_q == IDX_CAL)
        cal_q <= hwdata[15:0];
    end
  end

  // Set wins over any clear arriving in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      conversion_ready_flag_q <= 1'b0;
    else if (cif.done)
      conversion_ready_flag_q <= 1'b1;
    else if (cfg_wr && (new_mode != 3'b000) && (new_mode != 3'b100))
      conversion_ready_flag_q <= 1'b0;
    else if (status_rd)
      conversion_ready_flag_q <= 1'b0;
    else if (pin_trig)
      conversion_ready_flag_q <= 1'b0;
  end

  // Single-shot request, held until the sequencer picks it up
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trig_pend_q <= 1'b0;
      pin_q       <= 1'b0;
    end
    else
    begin
      pin_q <= convert_pin;
      if (new_trig || pin_trig)
        trig_pend_q <= 1'b1;
      else if (cfg_wr || (seq_go && state_q == SBC_ST_IDLE))
        trig_pend_q <= 1'b0;
    end
  end

  // Recovery timer reloads while powered down, counts down after leaving
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wake_cnt_q <= 11'd0;
    else if (mode == SBC_MODE_PDOWN)
      wake_cnt_q <= 11'(RECOVERY_CYC);
    else if (wake_cnt_q != 11'd0)
      wake_cnt_q <= wake_cnt_q - 11'd1;
  end

  assign seq_go = (wake_cnt_q == 11'd0) && (mode != SBC_MODE_PDOWN)
                  && (mode != SBC_MODE_OFF)
                  && (mode_cont || trig_pend_q);

  assign avg_log2 = (state_q == SBC_ST_BUS) ? avg_shift(bavg_field) : avg_shift(savg_field);
  assign avg_last = 7'((8'd1 << avg_log2) - 8'd1);
  assign acc_sum  = acc_q + ((state_q == SBC_ST_BUS)
                    ? $signed({{(DATA_W-BUS_W+7){1'b0}}, adc_data[BUS_W-1:0]})
                    : $signed({{7{adc_data[DATA_W-1]}}, adc_data}));
  assign avg_val  = DATA_W'(acc_sum >>> avg_log2);

  // Conversion sequencer; a config write aborts a cycle in progress
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q      <= SBC_ST_IDLE;
      samp_cnt_q   <= 7'd0;
      acc_q        <= '0;
      calc_start_q <= 1'b0;
      shunt_q      <= '0;
      bus_q        <= '0;
    end
    else
    begin
      calc_start_q <= 1'b0;
      if (cfg_wr)
      begin
        state_q    <= SBC_ST_IDLE;
        samp_cnt_q <= 7'd0;
        acc_q      <= '0;
      end
      else
      begin
        case (state_q)
          SBC_ST_IDLE:
          begin
            if (seq_go)
              state_q <= mode[0] ? SBC_ST_SHUNT : SBC_ST_BUS;
          end
          SBC_ST_SHUNT:
          begin
            if (adc_done)
            begin
              if (samp_cnt_q == avg_last)
              begin
                shunt_q    <= avg_val;
                samp_cnt_q <= 7'd0;
                acc_q      <= '0;
                if (mode[1])
                  state_q <= SBC_ST_BUS;
                else
                begin
                  state_q      <= SBC_ST_CALC;
                  calc_start_q <= 1'b1;
                end
              end
              else
              begin
                acc_q      <= acc_sum;
                samp_cnt_q <= samp_cnt_q + 7'd1;
              end
            end
          end
          SBC_ST_BUS:
          begin
            if (adc_done)
            begin
              if (samp_cnt_q == avg_last)
              begin
                bus_q        <= avg_val[BUS_W-1:0];
                samp_cnt_q   <= 7'd0;
                acc_q        <= '0;
                state_q      <= SBC_ST_CALC;
                calc_start_q <= 1'b1;
              end
              else
              begin
                acc_q      <= acc_sum;
                samp_cnt_q <= samp_cnt_q + 7'd1;
              end
            end
          end
          SBC_ST_CALC:
          begin
            if (cif.done)
            begin
              if (mode_cont && seq_go)
                state_q <= mode[0] ? SBC_ST_SHUNT : SBC_ST_BUS;
              else
                state_q <= SBC_ST_IDLE;
            end
          end
          default:
            state_q <= SBC_ST_IDLE;
        endcase
      end
    end
  end

  assign cif.start = calc_start_q;
  assign cif.shunt = shunt_q;
  assign cif.bus   = bus_q;
  assign cif.cal   = cal_q;

  assign adc_req      = (state_q == SBC_ST_SHUNT) || (state_q == SBC_ST_BUS);
  assign adc_chan_bus = (state_q == SBC_ST_BUS);

  // Range and power controls registered for the analog side
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      adc_res          <= 2'b11;
      shunt_gain       <= 2'b11;
      shunt_fs_mv      <= 9'd320;
      bus_range_select <= 1'b1;
      bus_fs_v         <= BUS_FS_HIGH_V;
      powered_down     <= 1'b0;
    end
    else
    begin
      adc_res     <= (state_q == SBC_ST_BUS)
                     ? (bavg_field[3] ? 2'b11 : bavg_field[1:0])
                     : (savg_field[3] ? 2'b11 : savg_field[1:0]);
      shunt_gain  <= cfg_q[CFG_GAIN_LSB +: 2];
      shunt_fs_mv <= SHUNT_FS_BASE_MV << cfg_q[CFG_GAIN_LSB +: 2];
      bus_range_select <= cfg_q[CFG_BUS_RANGE_SELECT_BIT];
      bus_fs_v    <= cfg_q[CFG_BUS_RANGE_SELECT_BIT] ? BUS_FS_HIGH_V : BUS_FS_LOW_V;
      powered_down <= (mode == SBC_MODE_PDOWN);
    end
  end
endmodule
`default_nettype wire

//--- tb/sbc_adc_model.sv
// Behavioural converter front end: one sample after a set delay per request.
// Assumes request and channel stay put until the sample is delivered.
`default_nettype none
module sbc_adc_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Sequencer side
  input  wire logic        adc_req,
  input  wire logic        adc_chan_bus,
  output logic             adc_done,
  output logic      [15:0] adc_data,
  // Bench controls
  input  wire logic [3:0]  delay,
  input  wire logic [15:0] shunt_val,
  input  wire logic [12:0] bus_val
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q    <= 4'h0;
      adc_done <= 1'b0;
      adc_data <= 16'h5a5a;
    end
    else
    begin
      adc_done <= 1'b0;
      // Data is only valid with done; toggling shows any late sampling
      adc_data <= ~adc_data;
      if (!adc_req || adc_done)
        cnt_q <= 4'h0;
      else if (cnt_q >= delay)
      begin
        adc_done <= 1'b1;
        adc_data <= adc_chan_bus ? {3'h0, bus_val} : shunt_val;
        cnt_q    <= 4'h0;
      end
      else
        cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/sbc_top_chk.sv
// Checker for the conversion sequencer: modes, ranges and request order.
// Assumes it is bound into sbc_top and config writes are single words.
`default_nettype none
module sbc_top_chk
  import sbc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Bus address phase and write data
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Converter and ranges
  input wire logic        adc_req,
  input wire logic        adc_chan_bus,
  input wire logic        adc_done,
  input wire logic [1:0]  shunt_gain,
  input wire logic [8:0]  shunt_fs_mv,
  input wire logic        bus_range_select,
  input wire logic [5:0]  bus_fs_v
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        cfg_dp_q;
  logic [2:0]  mode_q;
  logic [1:0]  gain_q;
  logic        bus_range_select_q;
  logic [10:0] rec_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the last config word, captured at the end of its data phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_dp_q <= 1'b0;
      mode_q   <= CFG_RESET[2:0];
      gain_q   <= CFG_RESET[12:11];
      bus_range_select_q   <= CFG_RESET[13];
    end
    else
    begin
      cfg_dp_q <= hsel && htrans[1] && hready && hwrite && (haddr == 32'h0);
      if (cfg_dp_q)
      begin
        mode_q <= hwdata[2:0];
        gain_q <= hwdata[12:11];
        bus_range_select_q <= hwdata[CFG_BUS_RANGE_SELECT_BIT];
      end
    end
  end
  // Cycles since the mode left power-down, saturating
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rec_q <= 11'h7ff;
    else if (mode_q == SBC_MODE_PDOWN)
      rec_q <= 11'h0;
    else if (rec_q != 11'h7ff)
      rec_q <= rec_q + 11'h1;
  end
  property p_off_halt;
    (mode_q == SBC_MODE_OFF) && $stable(mode_q) |-> !adc_req;
  endproperty
  a_off_halt: assert property (p_off_halt) else $error("request while off");
  property p_recover;
    adc_req |-> rec_q >= 11'(RECOVERY_CYC);
  endproperty
  a_recover: assert property (p_recover) else $error("request in recovery");
  property p_shunt_fs;
    shunt_fs_mv == (SHUNT_FS_BASE_MV << shunt_gain);
  endproperty
  a_shunt_fs: assert property (p_shunt_fs) else $error("shunt range");
  property p_bus_fs;
    bus_fs_v == (bus_range_select ? BUS_FS_HIGH_V : BUS_FS_LOW_V);
  endproperty
  a_bus_fs: assert property (p_bus_fs) else $error("bus range");
  property p_range;
    cfg_dp_q |-> ##[1:2] (bus_range_select == bus_range_select_q && shunt_gain == gain_q);
  endproperty
  a_range: assert property (p_range) else $error("range not from config");
  property p_req_hold;
    adc_req && !adc_done && !cfg_dp_q |=> adc_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_chan;
    adc_req && $stable(mode_q) |->
      !((mode_q[1:0] == 2'b01 && adc_chan_bus) || (mode_q[1:0] == 2'b10 && !adc_chan_bus));
  endproperty
  a_chan: assert property (p_chan) else $error("wrong channel for mode");
  property p_idle;
    $fell(adc_req) && !mode_q[2] && !$past(cfg_dp_q) |-> (!adc_req) [*4];
  endproperty
  a_idle: assert property (p_idle) else $error("shot repeated");
endmodule
bind sbc_top sbc_top_chk u_chk (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .adc_req(adc_req), .adc_chan_bus(adc_chan_bus),
  .adc_done(adc_done), .shunt_gain(shunt_gain), .shunt_fs_mv(shunt_fs_mv),
  .bus_range_select(bus_range_select), .bus_fs_v(bus_fs_v)
);
`default_nettype wire

//--- tb/tb.sv
// Register-level bench for the conversion sequencer over AHB-Lite.
// Assumes a single slave, so hreadyout feeds hready back.
`default_nettype none
module tb
  import sbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, convert_pin = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, shunt_gain, adc_res;
  logic        hreadyout, hresp, adc_req, adc_chan_bus, adc_done, bus_range_select, powered_down;
  logic [15:0] adc_data;
  logic [8:0]  shunt_fs_mv;
  logic [5:0]  bus_fs_v;
  logic [3:0]  delay = 4'h2;
  logic [7:0]  seq = 8'h0;
  int          n_mismatch = 0, comparisons = 0, n_done = 0, cycles = 0, n0, i, t;
  always #12.5 clk = ~clk;
  sbc_top dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .convert_pin(convert_pin), .adc_req(adc_req),
    .adc_chan_bus(adc_chan_bus), .adc_res(adc_res), .adc_done(adc_done), .adc_data(adc_data),
    .shunt_gain(shunt_gain), .shunt_fs_mv(shunt_fs_mv), .bus_range_select(bus_range_select),
    .bus_fs_v(bus_fs_v), .powered_down(powered_down)
  );
  sbc_adc_model u_adc (
    .clk(clk), .rst(rst), .adc_req(adc_req), .adc_chan_bus(adc_chan_bus),
    .adc_done(adc_done), .adc_data(adc_data), .delay(delay), .shunt_val(16'hff9c),
    .bus_val(13'h3e8)
  );
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Sample log: count of accepted samples and their channel order
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (adc_done && adc_req)
    begin
      n_done <= n_done + 1;
      seq    <= {seq[6:0], adc_chan_bus};
    end
    if (cycles == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
    ahb(1'b1, {26'h0, idx, 2'b00}, wd);
  endtask
  task automatic rd_chk(input logic [3:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    ahb(1'b0, {26'h0, idx, 2'b00}, 32'h0);
    chk(rd & mask, exp);
  endtask
  // Polls the flag copy in the bus register, whose read leaves the flag alone
  task automatic wait_flag();
    rd = 32'h0;
    for (int k = 0; k < 200 && rd[BUS_READY_BIT] !== 1'b1; k++)
      ahb(1'b0, {26'h0, IDX_BUS, 2'b00}, 32'h0);
    chk(rd & 32'h2, 32'h2);
  endtask
  task automatic pulse_pin();
    @(posedge clk);
    convert_pin <= 1'b1;
    repeat (2) @(posedge clk);
    convert_pin <= 1'b0;
  endtask
  function automatic logic [31:0] cfg(input logic [2:0] m, input logic [3:0] s = 4'h3,
                                      input logic [3:0] b = 4'h3, input logic [1:0] g = 2'h3,
                                      input logic r = 1'b1);
    return {18'h0, r, g, b, s, m};
  endfunction
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(IDX_CONFIG, 32'hffffffff, 32'h399f);
    chk(32'(shunt_fs_mv), 32'h140);
    chk(32'(bus_fs_v), 32'h20);
    ahb(1'b0, 32'h100, 32'h0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    wr(IDX_CAL, 32'h2000);
    wait_flag();
    ahb(1'b0, {26'h0, IDX_STATUS, 2'b00}, 32'h0);
    wait_flag();
    rd_chk(IDX_SHUNT, 32'hffffffff, 32'hff9c);
    rd_chk(IDX_BUS, 32'hfffffffd, 32'h1f40);
    rd_chk(IDX_CURRENT, 32'hffffffff, 32'hff38);
    rd_chk(IDX_POWER, 32'hffffffff, 32'h28);
    delay <= 4'h9;
    wr(IDX_CONFIG, cfg(SBC_MODE_TRIG_ALL));
    wait_flag();
    n0 = n_done;
    repeat (20) @(posedge clk);
    chk(32'(n_done - n0), 32'h0);
    wr(IDX_CONFIG, cfg(SBC_MODE_TRIG_ALL));
    rd_chk(IDX_BUS, 32'h2, 32'h0);
    wait_flag();
    rd_chk(IDX_STATUS, 32'h1, 32'h1);
    rd_chk(IDX_STATUS, 32'h1, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      pulse_pin();
      rd_chk(IDX_BUS, 32'h2, 32'h0);
      wait_flag();
    end
    wr(IDX_CONFIG, cfg(SBC_MODE_OFF));
    rd_chk(IDX_BUS, 32'h2, 32'h2);
    n0 = n_done;
    for (i = 0; i < 4; i++)
    begin
      wr(IDX_CONFIG, cfg(SBC_MODE_OFF, 4'(i), 4'h3, i[1:0], i[0]));
      repeat (2) @(posedge clk);
      chk(32'(adc_res), 32'(i[1:0]));
      chk(32'(shunt_fs_mv), 32'h28 << i);
      chk(32'(bus_range_select), 32'(i[0]));
      chk(32'(bus_fs_v), i[0] ? 32'h20 : 32'h10);
    end
    chk(32'(n_done - n0), 32'h0);
    wr(IDX_CONFIG, cfg(SBC_MODE_PDOWN));
    rd_chk(IDX_BUS, 32'h2, 32'h2);
    chk(32'(powered_down), 32'h1);
    wr(IDX_CONFIG, cfg(SBC_MODE_TRIG_SH));
    rd_chk(IDX_BUS, 32'h2, 32'h0);
    n0 = n_done;
    for (t = 0; t < 2000 && adc_req !== 1'b1; t++)
      @(posedge clk);
    chk(32'(t >= 1580 && t <= 1620), 32'h1);
    wait_flag();
    chk(32'(n_done - n0), 32'h1);
    chk(32'(seq[0]), 32'h0);
    n0 = n_done;
    wr(IDX_CONFIG, cfg(SBC_MODE_TRIG_BUS));
    wait_flag();
    chk(32'(n_done - n0), 32'h1);
    chk(32'(seq[0]), 32'h1);
    n0 = n_done;
    wr(IDX_CONFIG, cfg(SBC_MODE_TRIG_ALL, 4'h9, 4'ha, 2'h1, 1'b0));
    wait_flag();
    chk(32'(n_done - n0), 32'h6);
    chk(32'(seq[5:0]), 32'h0f);
    rd_chk(IDX_SHUNT, 32'hffffffff, 32'hff9c);
    rd_chk(IDX_BUS, 32'hfffffffd, 32'h1f40);
    print_verdict();
  end
endmodule
`default_nettype wire
